// ==== common/assc_pkg.sv ====
// Constants, types and helpers shared by the ADC sample sequencer control block
package assc_pkg;
   localparam int NSEQ = 4;

   // ==========================================================
   // Register map
   localparam logic [11:0] OFS_ACT  = 12'h000;
   localparam logic [11:0] OFS_RIS  = 12'h004;
   localparam logic [11:0] OFS_IM   = 12'h008;
   localparam logic [11:0] OFS_ISC  = 12'h00c;
   localparam logic [11:0] OFS_OST  = 12'h010;
   localparam logic [11:0] OFS_EMUX = 12'h014;
   localparam logic [11:0] OFS_UST  = 12'h018;
   localparam logic [11:0] OFS_PRI  = 12'h020;
   localparam logic [11:0] OFS_PSSI = 12'h028;
   localparam logic [11:0] OFS_SAC  = 12'h030;
   // Sequencer windows at 0x040 + n*0x020, selected by paddr[7:5]
   localparam logic [2:0]  SEQ_WIN_LO = 3'h2;
   localparam logic [2:0]  SEQ_WIN_HI = 3'h5;
   localparam logic [4:0]  SQ_MUX  = 5'h00;
   localparam logic [4:0]  SQ_CTL  = 5'h04;
   localparam logic [4:0]  SQ_FIFO = 5'h08;
   localparam logic [4:0]  SQ_FST  = 5'h0c;

   // ==========================================================
   // Reset values and fields
   localparam logic [15:0] RST_PRI = 16'h3210;
   localparam logic [2:0]  RST_SAC = 3'h0;
   localparam logic [2:0]  SAC_MAX = 3'h6;
   localparam int CTL_DIFF = 0;
   localparam int CTL_END  = 1;
   localparam int CTL_IE   = 2;
   localparam int CTL_TEMP = 3;
   localparam int FST_HEAD  = 4;
   localparam int FST_EMPTY = 8;
   localparam int FST_FULL  = 12;

   // ==========================================================
   // Trigger source codes
   localparam logic [3:0] TRG_PROC   = 4'h0;
   localparam logic [3:0] TRG_COMP   = 4'h1;
   localparam logic [3:0] TRG_GPIO   = 4'h4;
   localparam logic [3:0] TRG_TIMER  = 4'h5;
   localparam logic [3:0] TRG_PWM    = 4'h6;
   localparam logic [3:0] TRG_ALWAYS = 4'hf;

   // ==========================================================
   // Converter clock
   localparam int PCLK_HZ = 250_000_000;
   localparam int ADC_HZ  = 16_667_000;
   localparam int ADC_DIV = (PCLK_HZ + ADC_HZ - 1) / ADC_HZ;
   localparam logic [3:0] ADC_DIV_M1 = 4'(ADC_DIV - 1);
   localparam logic [3:0] ADC_HALF   = 4'(ADC_DIV / 2);

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_START = 2'b01,
      ST_WAIT  = 2'b10
   } assc_state_t;

   typedef struct packed {
      logic       start;
      logic [3:0] input_sel;
      logic       diff;
      logic       temp;
   } assc_conv_req_t;

   typedef struct packed {
      logic       done;
      logic [9:0] data;
   } assc_conv_res_t;

   typedef struct packed {
      logic comp;
      logic timer;
      logic pwm;
      logic gpio;
   } assc_trig_t;

   function automatic logic [3:0] assc_depth(input logic [1:0] s);
      case (s)
         2'd0:    assc_depth = 4'h8;
         2'd3:    assc_depth = 4'h1;
         default: assc_depth = 4'h4;
      endcase
   endfunction : assc_depth

   function automatic logic [2:0] assc_inc(input logic [2:0] p, input logic [1:0] s);
      assc_inc = ({1'b0, p} == assc_depth(s) - 4'h1) ? 3'h0 : 3'(p + 3'h1);
   endfunction : assc_inc
endpackage : assc_pkg

// ==== logic/assc_top.sv ====
// APB register file, arbiter, step sequencer, averager and result FIFOs of the ADC control
//
// Overview of operation
// - Four sequencers: 8 steps/8 entries, two of 4/4, one of 1/1.
// - FIFO entries read as 32-bit words, result in the low 10 bits.
// - Each step has an input nibble and a control nibble (temp, ie, end, diff).
// - A sequencer runs only while its enable bit is set.
// - The same input may appear in several steps and is converted each time.
// - Each step with its interrupt enable set raises the raw interrupt.
// - The end bit in any step finishes the sequence after that step.
// - Reading the result port pops the oldest entry of a circular FIFO.
// - Head, tail, full and empty of each FIFO are readable.
// - Overflow and underflow are recorded per sequencer in separate registers.
// - Conversions are paced by a divided clock of about 16.667 MHz.
// - Raw interrupts come from step settings; the mask gates the output.
// - Raw view shows all sources, masked view only unmasked ones.
// - Writing one clears a sequencer interrupt; zero does nothing.
// - Concurrent pending triggers are served by priority, 0 highest.
// - Each sequencer selects its trigger source in its own field.
// - Writing one to a kick bit triggers a processor-sourced sequencer.
// - Averaging accumulates up to 64 conversions into one FIFO entry.
// - Averaging is off after reset; every result goes straight in.
// - One averager applies the same factor to every step.
// - Priority resets to 0x3210, sequencer 0 highest.
`timescale 1ns/1ps
module assc_top
   import assc_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire logic [11:0]    paddr,
   input  wire logic           psel,
   input  wire logic           penable,
   input  wire logic           pwrite,
   input  wire logic [31:0]    pwdata,
   output logic      [31:0]    prdata,
   output logic                pready,
   output logic                pslverr,
   input  wire assc_trig_t     trig_events,
   output assc_conv_req_t      conv_req,
   input  wire assc_conv_res_t conv_res,
   output logic                adc_clk,
   output logic      [3:0]     seq_irq
);

   // ==========================================================
   // State
   logic [3:0]     act_r, act_nxt, im_r, im_nxt, ris_r, ris_nxt;
   logic [3:0]     ost_r, ost_nxt, ust_r, ust_nxt, pend_r, pend_nxt;
   logic [15:0]    emux_r, emux_nxt, pri_r, pri_nxt;
   logic [2:0]     sac_r, sac_nxt;
   logic [31:0]    mux_r [NSEQ];
   logic [31:0]    mux_nxt [NSEQ];
   logic [31:0]    ctl_r [NSEQ];
   logic [31:0]    ctl_nxt [NSEQ];
   logic [9:0]     mem_r [NSEQ][8];
   logic [9:0]     mem_nxt [NSEQ][8];
   logic [2:0]     head_r [NSEQ];
   logic [2:0]     head_nxt [NSEQ];
   logic [2:0]     tail_r [NSEQ];
   logic [2:0]     tail_nxt [NSEQ];
   logic [3:0]     cnt_r [NSEQ];
   logic [3:0]     cnt_nxt [NSEQ];
   assc_state_t    state_r, state_nxt;
   logic [1:0]     cur_r, cur_nxt;
   logic [2:0]     step_r, step_nxt;
   logic [5:0]     avg_r, avg_nxt;
   logic [15:0]    acc_r, acc_nxt;
   logic [3:0]     div_r, div_nxt;
   logic           clk_r, clk_nxt;
   assc_conv_req_t req_r, req_nxt;
   logic [31:0]    prdata_r, prdata_nxt;
   logic           err_r, err_nxt;

   // Combinational helpers
   logic           tick, setup, wr, rd, in_seq, last_avg, hit;
   logic [1:0]     sidx;
   logic [4:0]     sofs;
   logic [3:0]     nib_ctl, nib_in, push, pop;
   logic [15:0]    acc_sum;
   logic [2:0]     pk;

   // Ties resolve to the lowest index, but software must avoid them
   function automatic logic [2:0] pick(input logic [3:0] p, input logic [15:0] pr);
      logic [2:0] r;
      logic [1:0] bp;
      r  = 3'h0;
      bp = 2'h3;
      for (int i = NSEQ - 1; i >= 0; i--) begin
         if (p[i] && (!r[2] || pr[4*i +: 2] <= bp)) begin
            r  = {1'b1, 2'(i)};
            bp = pr[4*i +: 2];
         end
      end
      return r;
   endfunction : pick

   // ==========================================================
   // Next-state logic
   always_comb begin
      act_nxt = act_r;  im_nxt = im_r;  ris_nxt = ris_r;
      ost_nxt = ost_r;  ust_nxt = ust_r;  pend_nxt = pend_r;
      emux_nxt = emux_r;  pri_nxt = pri_r;  sac_nxt = sac_r;
      mux_nxt = mux_r;  ctl_nxt = ctl_r;  mem_nxt = mem_r;
      head_nxt = head_r;  tail_nxt = tail_r;  cnt_nxt = cnt_r;
      state_nxt = state_r;  cur_nxt = cur_r;  step_nxt = step_r;
      avg_nxt = avg_r;  acc_nxt = acc_r;
      req_nxt = req_r;
      req_nxt.start = 1'b0;
      prdata_nxt = prdata_r;
      err_nxt = err_r;
      push = 4'h0;
      pop  = 4'h0;
      hit  = 1'b0;

      // Converter clock divider
      tick    = (div_r == ADC_DIV_M1);
      div_nxt = tick ? 4'h0 : 4'(div_r + 4'h1);
      clk_nxt = (div_nxt < ADC_HALF);

      setup  = psel && !penable;
      wr     = psel && penable && pwrite;
      rd     = psel && penable && !pwrite;
      sidx   = 2'(paddr[7:5] - SEQ_WIN_LO);
      sofs   = paddr[4:0];
      in_seq = (paddr[11:8] == 4'h0) && (paddr[7:5] >= SEQ_WIN_LO)
               && (paddr[7:5] <= SEQ_WIN_HI) && (paddr[1:0] == 2'h0);

      // Read data is captured in the setup cycle so prdata is a flop
      if (setup) begin
         prdata_nxt = 32'h0;
         err_nxt    = 1'b0;
         case (paddr)
            OFS_ACT:  prdata_nxt = {28'h0, act_r};
            OFS_RIS:  prdata_nxt = {28'h0, ris_r};
            OFS_IM:   prdata_nxt = {28'h0, im_r};
            OFS_ISC:  prdata_nxt = {28'h0, ris_r & im_r};
            OFS_OST:  prdata_nxt = {28'h0, ost_r};
            OFS_EMUX: prdata_nxt = {16'h0, emux_r};
            OFS_UST:  prdata_nxt = {28'h0, ust_r};
            OFS_PRI:  prdata_nxt = {16'h0, pri_r};
            OFS_PSSI: prdata_nxt = 32'h0;
            OFS_SAC:  prdata_nxt = {29'h0, sac_r};
            default: begin
               if (in_seq) begin
                  case (sofs)
                     SQ_MUX:  prdata_nxt = mux_r[sidx];
                     SQ_CTL:  prdata_nxt = ctl_r[sidx];
                     SQ_FIFO: prdata_nxt = {22'h0, mem_r[sidx][head_r[sidx]]};
                     SQ_FST: begin
                        prdata_nxt = {29'h0, tail_r[sidx]};
                        prdata_nxt[FST_HEAD +: 3] = head_r[sidx];
                        prdata_nxt[FST_EMPTY]     = (cnt_r[sidx] == 4'h0);
                        prdata_nxt[FST_FULL]      = (cnt_r[sidx] == assc_depth(sidx));
                     end
                     default: err_nxt = 1'b1;
                  endcase
               end else begin
                  err_nxt = 1'b1;
               end
            end
         endcase
      end

      // Register writes take effect at the access edge
      if (wr) begin
         case (paddr)
            OFS_ACT:  act_nxt = pwdata[3:0];
            OFS_IM:   im_nxt = pwdata[3:0];
            OFS_ISC:  ris_nxt = ris_r & ~pwdata[3:0];
            OFS_OST:  ost_nxt = ost_r & ~pwdata[3:0];
            OFS_UST:  ust_nxt = ust_r & ~pwdata[3:0];
            OFS_EMUX: emux_nxt = pwdata[15:0];
            OFS_PRI:  pri_nxt = pwdata[15:0] & 16'h3333;
            OFS_SAC:  sac_nxt = (pwdata[2:0] > SAC_MAX) ? SAC_MAX : pwdata[2:0];
            default: begin
               if (in_seq && sofs == SQ_MUX) begin
                  mux_nxt[sidx] = pwdata
                     & 32'((64'h1 << {assc_depth(sidx), 2'b00}) - 64'h1);
               end
               if (in_seq && sofs == SQ_CTL) begin
                  ctl_nxt[sidx] = pwdata
                     & 32'((64'h1 << {assc_depth(sidx), 2'b00}) - 64'h1);
               end
            end
         endcase
      end

      // Trigger capture
      for (int i = 0; i < NSEQ; i++) begin
         case (emux_r[4*i +: 4])
            TRG_PROC:   hit = wr && (paddr == OFS_PSSI) && pwdata[i];
            TRG_COMP:   hit = trig_events.comp;
            TRG_TIMER:  hit = trig_events.timer;
            TRG_PWM:    hit = trig_events.pwm;
            TRG_GPIO:   hit = trig_events.gpio;
            TRG_ALWAYS: hit = 1'b1;
            default:    hit = 1'b0;
         endcase
         if (!act_r[i]) begin
            pend_nxt[i] = 1'b0;
         end else if (hit) begin
            pend_nxt[i] = 1'b1;
         end
      end

      // Sequencer
      pk       = pick(pend_r & act_r, pri_r);
      nib_ctl  = ctl_r[cur_r][{step_r, 2'b00} +: 4];
      nib_in   = mux_r[cur_r][{step_r, 2'b00} +: 4];
      acc_sum  = 16'(acc_r + {6'h0, conv_res.data});
      last_avg = (avg_r == 6'((7'h1 << sac_r) - 7'h1));
      case (state_r)
         ST_IDLE: begin
            if (pk[2]) begin
               cur_nxt        = pk[1:0];
               step_nxt       = 3'h0;
               avg_nxt        = 6'h0;
               acc_nxt        = 16'h0;
               pend_nxt[pk[1:0]] = 1'b0;
               state_nxt      = ST_START;
            end
         end
         ST_START: begin
            if (!act_r[cur_r]) begin
               state_nxt = ST_IDLE;
            end else if (tick) begin
               req_nxt.start     = 1'b1;
               req_nxt.input_sel = nib_in;
               req_nxt.diff      = nib_ctl[CTL_DIFF];
               req_nxt.temp      = nib_ctl[CTL_TEMP];
               state_nxt         = ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (conv_res.done) begin
               acc_nxt   = acc_sum;
               state_nxt = ST_START;
               if (!last_avg) begin
                  avg_nxt = 6'(avg_r + 6'h1);
               end else begin
                  avg_nxt = 6'h0;
                  acc_nxt = 16'h0;
                  if (cnt_r[cur_r] == assc_depth(cur_r)) begin
                     ost_nxt[cur_r] = 1'b1;
                  end else begin
                     push[cur_r] = 1'b1;
                     mem_nxt[cur_r][tail_r[cur_r]] = 10'(acc_sum >> sac_r);
                  end
                  if (nib_ctl[CTL_IE]) begin
                     ris_nxt[cur_r] = 1'b1;
                  end
                  if (nib_ctl[CTL_END] || {1'b0, step_r} == assc_depth(cur_r) - 4'h1) begin
                     state_nxt = ST_IDLE;
                  end else begin
                     step_nxt = 3'(step_r + 3'h1);
                  end
               end
            end
         end
         default: state_nxt = ST_IDLE;
      endcase

      // Result port pops
      if (rd && in_seq && sofs == SQ_FIFO) begin
         if (cnt_r[sidx] == 4'h0) begin
            ust_nxt[sidx] = 1'b1;
         end else begin
            pop[sidx] = 1'b1;
         end
      end
      for (int i = 0; i < NSEQ; i++) begin
         if (push[i]) begin
            tail_nxt[i] = assc_inc(tail_r[i], 2'(i));
         end
         if (pop[i]) begin
            head_nxt[i] = assc_inc(head_r[i], 2'(i));
         end
         cnt_nxt[i] = 4'(cnt_r[i] + {3'h0, push[i]} - {3'h0, pop[i]});
      end
   end

   // ==========================================================
   // Registers
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         act_r    <= 4'h0;
         im_r     <= 4'h0;
         ris_r    <= 4'h0;
         ost_r    <= 4'h0;
         ust_r    <= 4'h0;
         pend_r   <= 4'h0;
         emux_r   <= 16'h0;
         pri_r    <= RST_PRI;
         sac_r    <= RST_SAC;
         mux_r    <= '{default: 32'h0};
         ctl_r    <= '{default: 32'h0};
         mem_r    <= '{default: '{default: 10'h0}};
         head_r   <= '{default: 3'h0};
         tail_r   <= '{default: 3'h0};
         cnt_r    <= '{default: 4'h0};
         state_r  <= ST_IDLE;
         cur_r    <= 2'h0;
         step_r   <= 3'h0;
         avg_r    <= 6'h0;
         acc_r    <= 16'h0;
         div_r    <= 4'h0;
         clk_r    <= 1'b0;
         req_r    <= '0;
         prdata_r <= 32'h0;
         err_r    <= 1'b0;
      end else begin
         act_r    <= act_nxt;
         im_r     <= im_nxt;
         ris_r    <= ris_nxt;
         ost_r    <= ost_nxt;
         ust_r    <= ust_nxt;
         pend_r   <= pend_nxt;
         emux_r   <= emux_nxt;
         pri_r    <= pri_nxt;
         sac_r    <= sac_nxt;
         mux_r    <= mux_nxt;
         ctl_r    <= ctl_nxt;
         mem_r    <= mem_nxt;
         head_r   <= head_nxt;
         tail_r   <= tail_nxt;
         cnt_r    <= cnt_nxt;
         state_r  <= state_nxt;
         cur_r    <= cur_nxt;
         step_r   <= step_nxt;
         avg_r    <= avg_nxt;
         acc_r    <= acc_nxt;
         div_r    <= div_nxt;
         clk_r    <= clk_nxt;
         req_r    <= req_nxt;
         prdata_r <= prdata_nxt;
         err_r    <= err_nxt;
      end
   end

   assign prdata   = prdata_r;
   assign pready   = 1'b1;
   assign pslverr  = psel && penable && err_r;
   assign conv_req = req_r;
   assign adc_clk  = clk_r;
   assign seq_irq  = ris_r & im_r;

   // ==========================================================
   // Assertions
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   step_irq_a: assert property (state_r == ST_WAIT && conv_res.done && last_avg
      && nib_ctl[CTL_IE] |=> ris_r[$past(cur_r)])
      else $error("Raw interrupt not raised after step");
   irq_mask_a: assert property ($rose(seq_irq[0]) |-> im_r[0] && ris_r[0])
      else $error("Interrupt output without mask");
   w1c_clear_a: assert property (wr && paddr == OFS_ISC && pwdata[1]
      && !(state_r == ST_WAIT && conv_res.done) |=> !ris_r[1])
      else $error("Write one did not clear interrupt");
   w0_keep_a: assert property (wr && paddr == OFS_ISC && !pwdata[2] && ris_r[2]
      |=> ris_r[2])
      else $error("Write zero changed interrupt");
   ovf_flag_a: assert property (state_r == ST_WAIT && conv_res.done && last_avg
      && cnt_r[cur_r] == assc_depth(cur_r) |=> ost_r[$past(cur_r)])
      else $error("Overflow not recorded");
   unf_flag_a: assert property (rd && in_seq && sofs == SQ_FIFO && cnt_r[sidx] == 4'h0
      |=> ust_r[$past(sidx)])
      else $error("Underflow not recorded");
   fifo_pop_a: assert property (rd && in_seq && sofs == SQ_FIFO && sidx == 2'd3
      && cnt_r[3] == 4'h1 |=> cnt_r[3] == 4'h0)
      else $error("Read did not pop entry");
   paced_start_a: assert property (req_r.start |-> $past(tick) && div_r == 4'h0)
      else $error("Conversion start off the converter clock");
   tick_gap_a: assert property (req_r.start |=> !req_r.start [*8])
      else $error("Conversion starts too close");
   best_pick_a: assert property (state_r == ST_IDLE && pk[2]
      |=> state_r == ST_START && cur_r == $past(pk[1:0]))
      else $error("Arbiter did not take best sequencer");
   no_preempt_a: assert property (state_r == ST_WAIT && !conv_res.done
      |=> state_r == ST_WAIT && $stable(cur_r))
      else $error("Sequence preempted");
   drop_disabled_a: assert property (!act_r[0] |=> !pend_r[0])
      else $error("Trigger left pending while disabled");
   end_step_a: assert property (state_r == ST_WAIT && conv_res.done && last_avg
      && nib_ctl[CTL_END] |=> state_r == ST_IDLE)
      else $error("Sequence did not end at end step");

   seq_irq_c: cover property (state_r == ST_WAIT ##[1:200] seq_irq != 4'h0);
   ovf_c: cover property (ost_r != 4'h0);
   avg_c: cover property (sac_r != 3'h0 && push != 4'h0);
   full_c: cover property (cnt_r[0] == 4'h8);

endmodule : assc_top

// ==== tb/assc_conv_model.sv ====
// Behavioural converter core that answers start pulses after a chosen delay
`timescale 1ns/1ps
module assc_conv_model
   import assc_pkg::*;
(
   input  wire logic           pclk,
   input  wire logic           presetn,
   input  wire assc_conv_req_t conv_req,
   input  wire logic [3:0]     lat,
   output assc_conv_res_t      conv_res
);
   logic       busy_r;
   logic [3:0] cnt_r;
   logic [9:0] val_r;
   // Data toggles between answers, so a stale sample never looks valid
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         {busy_r, cnt_r, val_r, conv_res} <= '0;
      end else begin
         conv_res <= '{done: 1'b0, data: ~conv_res.data};
         if (conv_req.start) begin
            busy_r <= 1'b1;
            cnt_r  <= lat;
            val_r  <= {3'h0, conv_req.temp, conv_req.diff, 1'b1, conv_req.input_sel};
         end else if (busy_r && cnt_r == 4'h0) begin
            busy_r   <= 1'b0;
            conv_res <= '{done: 1'b1, data: val_r};
         end else if (busy_r) begin
            cnt_r <= cnt_r - 4'h1;
         end
      end
   end
endmodule : assc_conv_model

// ==== tb/tb.sv ====
// Self-checking bench for the ADC sample sequencer control
`timescale 1ns/1ps
module tb import assc_pkg::*; ;
   logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, adc_clk, e;
   logic [11:0]    paddr;
   logic [31:0]    pwdata, prdata, q, m, c;
   logic [3:0]     seq_irq, lat = 4'h0;
   logic [3:0]     mux[8], ctl[8], sel_q[$];
   assc_trig_t     trig_events;
   assc_conv_req_t conv_req;
   assc_conv_res_t conv_res;
   logic [3:0]     codes[4] = '{TRG_COMP, TRG_TIMER, TRG_PWM, TRG_GPIO};
   int             seed = 23, miscompares = 0, check_count = 0, starts = 0;
   assc_top u_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .trig_events(trig_events), .conv_req(conv_req),
      .conv_res(conv_res), .adc_clk(adc_clk), .seq_irq(seq_irq));
   assc_conv_model u_conv (.pclk(pclk), .presetn(presetn), .conv_req(conv_req),
      .lat(lat), .conv_res(conv_res));
   initial begin
      pclk = 1'b0;
      forever #2 pclk = ~pclk;
   end
   // Every start is logged; the next answer delay is drawn at random
   always @(posedge pclk) begin
      if (conv_req.start === 1'b1) begin
         starts++;
         sel_q.push_back(conv_req.input_sel);
         lat <= 4'($random(seed));
      end
   end
   // ==========================================================
   // Bus and compare tasks
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge pclk);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge pclk);
      penable <= 1'b1;
      // Only the watchdog ends a wait for the slave
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      q = prdata;
      e = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic chk(input string nm, input logic [31:0] ex, input logic [31:0] got);
      check_count++;
      if (got !== ex) begin
         $display("mismatch %s expected %h seen %h", nm, ex, got);
         miscompares++;
      end
   endtask : chk
   // Wait for a status value under a bounded number of reads
   task automatic poll(input logic [11:0] a, input logic [31:0] mk, input logic [31:0] ex);
      int n = 0;
      do begin
         apb(1'b0, a, 32'h0);
         n++;
      end while ((q & mk) !== ex && n < 300);
      chk("poll", ex, q & mk);
   endtask : poll
   function automatic logic [31:0] exp_res(input logic [3:0] s, input logic [3:0] k);
      return {25'h0, k[CTL_TEMP], k[CTL_DIFF], 1'b1, s};
   endfunction : exp_res
   function automatic logic [11:0] sa(input int n, input logic [4:0] o);
      return 12'(32'h40 + 32'h20 * n) + {7'h0, o};
   endfunction : sa
   task automatic report_and_stop;
      $display("checks %0d mismatches %0d", check_count, miscompares);
      if (miscompares == 0 && check_count > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : report_and_stop
   initial begin
      #200000;
      miscompares++;
      report_and_stop();
   end
   // ==========================================================
   // Scenarios
   initial begin
      {presetn, psel, penable, pwrite, paddr, pwdata, trig_events} = '0;
      repeat (16) @(posedge pclk);
      presetn <= 1'b1;
      apb(1'b0, OFS_PRI, 32'h0);
      chk("pri", {16'h0, RST_PRI}, q);
      apb(1'b0, OFS_SAC, 32'h0);
      chk("sac", {29'h0, RST_SAC}, q);
      apb(1'b0, 12'h01c, 32'h0);
      chk("slverr", 32'h1, {31'h0, e});
      // Whole divider periods, so the count does not depend on phase
      c = 32'h0;
      repeat (4 * ADC_DIV) begin
         @(posedge pclk);
         c = c + {31'h0, adc_clk};
      end
      chk("adc_clk", 32'(4 * ADC_HALF), c);
      // End bit at the fifth step, a repeated input, random ie and diff
      for (int k = 0; k < 8; k++) begin
         mux[k] = 4'($random(seed));
         ctl[k] = {1'b0, (k == 4) | 1'($random(seed)), k == 4, 1'($random(seed))};
      end
      mux[1] = mux[0];
      for (int k = 0; k < 8; k++) begin
         m[4*k+:4] = mux[k];
         c[4*k+:4] = ctl[k];
      end
      apb(1'b1, sa(0, SQ_MUX), m);
      apb(1'b1, sa(0, SQ_CTL), c);
      apb(1'b1, OFS_ACT, 32'h1);
      starts = 0;
      apb(1'b1, OFS_PSSI, 32'h1);
      // Earlier steps may raise the interrupt, so wait for the fifth push
      poll(sa(0, SQ_FST), 32'h7, 32'h5);
      poll(OFS_RIS, 32'h1, 32'h1);
      chk("steps", 32'h5, starts);
      for (int k = 0; k < 5; k++) begin
         chk("sel", {28'h0, mux[k]}, {28'h0, sel_q.pop_front()});
         apb(1'b0, sa(0, SQ_FIFO), 32'h0);
         chk("fifo", exp_res(mux[k], ctl[k]), q);
      end
      apb(1'b0, sa(0, SQ_FST), 32'h0);
      chk("fstat", 32'h155, q & 32'h1177);
      apb(1'b0, sa(0, SQ_FIFO), 32'h0);
      poll(OFS_UST, 32'h1, 32'h1);
      apb(1'b1, OFS_IM, 32'h1);
      apb(1'b0, OFS_ISC, 32'h0);
      chk("masked", 32'h1, q);
      chk("irq", 32'h1, {28'h0, seq_irq});
      apb(1'b1, OFS_ISC, 32'h0);
      poll(OFS_RIS, 32'h1, 32'h1);
      apb(1'b1, OFS_ISC, 32'h1);
      poll(OFS_RIS, 32'h1, 32'h0);
      chk("irq", 32'h0, {28'h0, seq_irq});
      // Kick before enable is dropped, then averaging and overflow
      apb(1'b1, sa(3, SQ_MUX), 32'h5);
      apb(1'b1, sa(3, SQ_CTL), 32'he);
      starts = 0;
      apb(1'b1, OFS_PSSI, 32'h8);
      apb(1'b1, OFS_ACT, 32'h9);
      repeat (100) @(posedge pclk);
      chk("dropped", 32'h0, starts);
      apb(1'b1, OFS_SAC, 32'h2);
      apb(1'b1, OFS_PSSI, 32'h8);
      poll(OFS_RIS, 32'h8, 32'h8);
      chk("avg", 32'h4, starts);
      apb(1'b0, sa(3, SQ_FST), 32'h0);
      chk("full", 32'h1, {31'h0, q[FST_FULL]});
      apb(1'b1, OFS_PSSI, 32'h8);
      poll(OFS_OST, 32'h8, 32'h8);
      apb(1'b0, sa(3, SQ_FIFO), 32'h0);
      chk("fifo3", exp_res(4'h5, 4'he), q);
      apb(1'b1, OFS_SAC, 32'h0);
      // Concurrent kicks are served by priority; distinct values kept
      apb(1'b1, sa(1, SQ_MUX), 32'h3);
      apb(1'b1, sa(1, SQ_CTL), 32'h6);
      apb(1'b1, sa(2, SQ_MUX), 32'h9);
      apb(1'b1, sa(2, SQ_CTL), 32'h6);
      apb(1'b1, OFS_PRI, 32'h3012);
      apb(1'b1, OFS_ACT, 32'h6);
      sel_q.delete();
      apb(1'b1, OFS_PSSI, 32'h6);
      poll(OFS_RIS, 32'h6, 32'h6);
      chk("first", 32'h9, {28'h0, sel_q.pop_front()});
      chk("second", 32'h3, {28'h0, sel_q.pop_front()});
      apb(1'b0, sa(1, SQ_FIFO), 32'h0);
      apb(1'b1, OFS_ISC, 32'h6);
      // Each peripheral event source drives the second sequencer
      apb(1'b1, OFS_ACT, 32'h2);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, OFS_EMUX, {24'h0, codes[i], 4'h0});
         @(posedge pclk);
         trig_events <= assc_trig_t'(4'h8 >> i);
         @(posedge pclk);
         trig_events <= '0;
         poll(OFS_RIS, 32'h2, 32'h2);
         apb(1'b1, OFS_ISC, 32'h2);
         apb(1'b0, sa(1, SQ_FIFO), 32'h0);
         chk("event", exp_res(4'h3, 4'h6), q);
      end
      // Always source on the lowest priority must not starve a kicked sequencer
      apb(1'b1, OFS_ISC, 32'h8);
      apb(1'b1, OFS_EMUX, 32'hf000);
      apb(1'b1, OFS_ACT, 32'ha);
      apb(1'b1, OFS_PSSI, 32'h2);
      poll(OFS_RIS, 32'ha, 32'ha);
      apb(1'b0, sa(1, SQ_FIFO), 32'h0);
      chk("always", exp_res(4'h3, 4'h6), q);
      report_and_stop();
   end
endmodule : tb
